// ==== src/mct_pkg.sv ====
// mct_pkg: constants, register map and carrier types of the module
// control and status timing block.
// assumes a 250 MHz aclk and a 32-bit AXI4-Lite register bus.
package mct_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_MHZ         = 250;
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int T_INIT_MS       = 2000;
    localparam int T_RESET_MIN_NS  = 2000;
    localparam int T_LOW_POWER_REQUEST_US     = 100;
    localparam int T_INTERRUPT_OUT_N_ON_MS    = 200;
    localparam int T_INTERRUPT_OUT_N_OFF_US   = 500;
    localparam int T_LOS_MS        = 100;
    localparam int T_MASK_MS       = 100;
    localparam int T_SELECT_US     = 100;
    localparam int T_PDOWN_ON_MS   = 100;
    localparam int T_PDOWN_OFF_MS  = 300;

    // longest times round down; least times round up
    localparam int INIT_CYC_MAX    = T_INIT_MS * 1000 * CLK_MHZ;
    localparam int RESET_MIN_CYC   = (T_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOW_POWER_REQUEST_CYC_MAX  = T_LOW_POWER_REQUEST_US * CLK_MHZ;
    localparam int INTERRUPT_OUT_N_OFF_CYC    = T_INTERRUPT_OUT_N_OFF_US * CLK_MHZ;
    localparam int SELECT_CYC_MAX  = T_SELECT_US * CLK_MHZ;

    localparam int CNT_W           = 32;
    localparam logic [CNT_W-1:0] RESET_MIN_CNT = CNT_W'(RESET_MIN_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE       = 32'h0000_0001;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  ADDR_STATUS  = 8'h00;
    localparam logic [7:0]  ADDR_FLAGS   = 8'h04;
    localparam logic [7:0]  ADDR_MASK    = 8'h08;
    localparam logic [7:0]  ADDR_CONTROL = 8'h0C;

    // status fields
    localparam int ST_NOT_READY  = 0;
    localparam int ST_LOW_POWER  = 1;
    localparam int ST_BUS_ACTIVE = 2;
    localparam int ST_INT_ACTIVE = 3;
    localparam int ST_RESET_SEEN = 4;
    // control fields
    localparam int CT_PDOWN      = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int FLAG_W = 13;
    localparam logic [FLAG_W-1:0] MASK_RESET = 13'h0000;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [3:0] other;
        logic [3:0] tx_fault;
        logic [3:0] rx_los;
    } mct_cond_type;

    typedef struct packed {
        logic [3:0] other;
        logic [3:0] tx_fault;
        logic [3:0] rx_los;
        logic       ready;
    } mct_flag_type;

    typedef enum logic [1:0] {
        MCT_INIT,
        MCT_RUN,
        MCT_HELD
    } mct_state_type;

endpackage

// ==== src/mct_module_control.sv ====
// mct_module_control: readiness, reset recognition, low power, select,
// flags, masks and interrupt of a pluggable transceiver module.
// assumes all pins synchronous to aclk; an AXI4-Lite master owns the
// registers and stands in for the two-wire management bus.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - fully functional within 2000 ms after start
// - reset counts only if low over 2 us
// - answer management bus within 2000 ms
// - clear not-ready flag, assert interrupt, by 2000 ms
// - reinitialised within 2000 ms of reset release
// - low power within 100 us of request
// - interrupt low within 200 ms of condition
// - read clears flags; release interrupt within 500 us
// - loss of signal flagged within 100 ms
// - transmit fault flagged within 200 ms
// - other conditions flagged within 200 ms
// - set mask blocks interrupt within 100 ms
// - cleared mask resumes interrupt within 100 ms
// - select asserted: respond within 100 us
// - select released: stop responding within 100 us
// - power-down bit: low power within 100 ms
// - power-down cleared: functional within 300 ms (here only low power drops; no interrupt is raised)
// - functional means not-ready cleared, interrupt raised
// - write latencies timed from write completion
// - flag bits are read-only
// - mask bits are read/write
module mct_module_control
    import mct_pkg::*;
#(
    parameter logic [31:0] INIT_CYCLES = 32'(mct_pkg::INIT_CYC_MAX)
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [mct_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                s_axi_awprot,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [mct_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                s_axi_arprot,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      module_reset_n,
    input  wire logic                      low_power_request,
    input  wire logic                      module_select_n,
    input  wire mct_pkg::mct_cond_type     cond_in,
    output logic                           interrupt_out_n,
    output logic                           low_power_mode,
    output logic                           serial_bus_enable,
    output logic                           module_ready
);
    import mct_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return (a == ADDR_STATUS) || (a == ADDR_FLAGS) ||
               (a == ADDR_MASK) || (a == ADDR_CONTROL);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    mct_state_type       state_reg,      state_next;
    logic [CNT_W-1:0]    init_cnt_reg,   init_cnt_next;
    logic [CNT_W-1:0]    low_cnt_reg,    low_cnt_next;
    logic                reset_seen_reg, reset_seen_next;
    logic                rst_pin_reg;
    mct_cond_type        cond_prev_reg;
    mct_flag_type        flags_reg,      flags_next;
    logic [FLAG_W-1:0]   mask_reg,       mask_next;
    logic                pdown_reg,      pdown_next;
    logic                intr_n_reg;
    logic                lowp_reg;
    logic                bus_en_reg;

    logic                aw_full_reg;
    logic [ADDR_W-1:0]   aw_addr_reg;
    logic                w_full_reg;
    logic [31:0]         w_data_reg;
    logic [3:0]          w_strb_reg;
    logic                bvalid_reg;
    logic [1:0]          bresp_reg;
    logic                rvalid_reg;
    logic [31:0]         rdata_reg;
    logic [1:0]          rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    wire aw_take    = s_axi_awvalid & s_axi_awready;
    wire w_take     = s_axi_wvalid & s_axi_wready;
    wire ar_take    = s_axi_arvalid & s_axi_arready;
    wire do_write   = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire wr_mask    = do_write & (aw_addr_reg == ADDR_MASK);
    wire wr_control = do_write & (aw_addr_reg == ADDR_CONTROL);
    wire rd_flags   = ar_take & (s_axi_araddr == ADDR_FLAGS);
    wire ready_now  = (state_reg == MCT_RUN);

    wire [31:0] mask_word  = lane_merge({19'h0_0000, mask_reg}, w_data_reg, w_strb_reg);
    wire [31:0] ctrl_word  = lane_merge({31'h0000_0000, pdown_reg}, w_data_reg, w_strb_reg);

    assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_full_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // reset pin: recognised only after a long enough low

    assign low_cnt_next    = rst_pin_reg ? '0 :
                             (low_cnt_reg == RESET_MIN_CNT) ? low_cnt_reg :
                             low_cnt_reg + CNT_ONE;
    assign reset_seen_next = rst_pin_reg ? 1'b0 : (low_cnt_reg == RESET_MIN_CNT);

    ////////////////////////////////////////////////////////////////////////
    // initialisation sequence

    always_comb begin
        state_next    = state_reg;
        init_cnt_next = init_cnt_reg;
        unique case (state_reg)
            MCT_INIT: begin
                if (init_cnt_reg >= INIT_CYCLES - CNT_ONE) begin
                    state_next = MCT_RUN;
                end else begin
                    init_cnt_next = init_cnt_reg + CNT_ONE;
                end
            end
            MCT_RUN: begin
                init_cnt_next = '0;
            end
            MCT_HELD: begin
                init_cnt_next = '0;
                if (rst_pin_reg) begin
                    state_next = MCT_INIT;
                end
            end
            // unused code: restart the sequence
            default: begin
                state_next = MCT_INIT;
            end
        endcase
        // a short glitch on the pin never disturbs a running module
        if (reset_seen_next) begin
            state_next    = MCT_HELD;
            init_cnt_next = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: rising edges of conditions, sticky until read

    wire mct_cond_type cond_rise = cond_in & ~cond_prev_reg;
    wire enter_run = (state_reg == MCT_INIT) & (state_next == MCT_RUN);

    always_comb begin
        flags_next = flags_reg;
        if (rd_flags) begin
            flags_next = '0;
        end
        flags_next.rx_los   = flags_next.rx_los   | (cond_rise.rx_los   & {4{ready_now}});
        flags_next.tx_fault = flags_next.tx_fault | (cond_rise.tx_fault & {4{ready_now}});
        flags_next.other    = flags_next.other    | (cond_rise.other    & {4{ready_now}});
        flags_next.ready    = flags_next.ready | enter_run;
        if (state_next == MCT_HELD) begin
            flags_next = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writable registers, acted on the cycle after the write completes

    assign mask_next  = (state_next == MCT_HELD) ? MASK_RESET :
                        wr_mask ? mask_word[FLAG_W-1:0] : mask_reg;
    assign pdown_next = (state_next == MCT_HELD) ? 1'b0 :
                        wr_control ? ctrl_word[CT_PDOWN] : pdown_reg;

    wire intr_active = |(flags_reg & ~mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // read mux

    wire [31:0] status_word = {27'h000_0000, reset_seen_reg, ~intr_n_reg, bus_en_reg,
                               lowp_reg, ~ready_now};
    wire [31:0] rd_word = (s_axi_araddr == ADDR_STATUS)  ? status_word :
                          (s_axi_araddr == ADDR_FLAGS)   ? {19'h0_0000, flags_reg} :
                          (s_axi_araddr == ADDR_MASK)    ? {19'h0_0000, mask_reg} :
                          (s_axi_araddr == ADDR_CONTROL) ? {31'h0000_0000, pdown_reg} :
                          32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // sideband and core registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg      <= MCT_INIT;
            init_cnt_reg   <= '0;
            low_cnt_reg    <= '0;
            reset_seen_reg <= 1'b0;
            rst_pin_reg    <= 1'b1;
            cond_prev_reg  <= '0;
            flags_reg      <= '0;
            mask_reg       <= MASK_RESET;
            pdown_reg      <= 1'b0;
        end else begin
            state_reg      <= state_next;
            init_cnt_reg   <= init_cnt_next;
            low_cnt_reg    <= low_cnt_next;
            reset_seen_reg <= reset_seen_next;
            rst_pin_reg    <= module_reset_n;
            cond_prev_reg  <= cond_in;
            flags_reg      <= flags_next;
            mask_reg       <= mask_next;
            pdown_reg      <= pdown_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            intr_n_reg <= 1'b1;
            lowp_reg   <= 1'b0;
            bus_en_reg <= 1'b0;
        end else begin
            intr_n_reg <= ~intr_active;
            lowp_reg   <= low_power_request | pdown_reg;
            bus_en_reg <= ready_now & ~module_select_n;
        end
    end

    assign interrupt_out_n   = intr_n_reg;
    assign low_power_mode    = lowp_reg;
    assign serial_bus_enable = bus_en_reg;
    assign module_ready      = ready_now;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_full_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            // status and flags ignore writes but still answer okay
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= addr_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_word;
                rresp_reg  <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== test/mct_host_sideband.sv ====
// mct_host_sideband: host side of the module reset pin
// assumes pulses are requested by the bench one at a time on aclk
`timescale 1ns/1ps
`default_nettype none
module mct_host_sideband (
    input  wire logic        aclk,
    input  wire logic        pulse_go,
    input  wire logic [15:0] pulse_len,
    output logic             module_reset_n,
    output logic             pulse_busy
);
    logic [15:0] cnt_reg = 16'h0000;
    always_ff @(posedge aclk) begin
        if (pulse_go && !pulse_busy) begin
            cnt_reg <= pulse_len;
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end
    assign pulse_busy     = cnt_reg != 16'h0000;
    assign module_reset_n = cnt_reg == 16'h0000;
endmodule
`default_nettype wire

// ==== test/mct_module_control_properties.sv ====
// checker: timing relations at the ports of mct_module_control
// assumes one aclk domain and a synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module mct_module_control_properties
    import mct_pkg::*;
#(
    parameter logic [31:0] INIT_CYCLES = 32'h0000_0014
) (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic [mct_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic [mct_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic                       module_reset_n,
    input wire logic                       low_power_request,
    input wire logic                       module_select_n,
    input wire mct_pkg::mct_cond_type      cond_in,
    input wire logic                       interrupt_out_n,
    input wire logic                       low_power_mode,
    input wire logic                       serial_bus_enable,
    input wire logic                       module_ready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [11:0] cond_q_reg;
    logic [31:0] low_cnt_reg;
    logic [31:0] init_cnt_reg;
    logic        mask_clean_reg;
    wire         cond_rise = |(cond_in & ~cond_q_reg);
    wire         mask_wr   = s_axi_awvalid && s_axi_awready && s_axi_awaddr == ADDR_MASK;
    // masks hide interrupts, so the interrupt-raising checks stop after any mask write
    always_ff @(posedge aclk) begin
        cond_q_reg     <= cond_in;
        low_cnt_reg    <= (!aresetn || module_reset_n) ? 32'h0 : low_cnt_reg + 32'h1;
        init_cnt_reg   <= (!aresetn || !module_reset_n || module_ready) ? 32'h0
                                                                       : init_cnt_reg + 32'h1;
        mask_clean_reg <= !aresetn || (mask_clean_reg && !mask_wr);
    end
    ////////////////////////////////////////////////////////////////////
    sequence s_quiet_flag_read;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_FLAGS && module_ready
         && !cond_rise) ##1 !cond_rise;
    endsequence
    AST_LOW_POWER_REQUEST: assert property ($past(aresetn) && low_power_request |=> low_power_mode)
        else $error("low power request not followed");
    AST_SEL_ON: assert property (module_ready && !module_select_n |=> serial_bus_enable)
        else $error("selected module not answering");
    AST_SEL_OFF: assert property (module_select_n |=> !serial_bus_enable)
        else $error("deselected module still answering");
    AST_INIT_BOUND: assert property (init_cnt_reg <= INIT_CYCLES + 32'h4)
        else $error("initialisation too long");
    AST_READY_INT: assert property ($rose(module_ready) && mask_clean_reg |->
        ##[1:2] !interrupt_out_n)
        else $error("no interrupt on readiness");
    AST_COND_INT: assert property ($past(aresetn) && module_ready && mask_clean_reg && cond_rise
        |-> ##[1:2] !interrupt_out_n)
        else $error("no interrupt on condition");
    AST_FLAG_CLEAR: assert property (s_quiet_flag_read |-> ##[0:1] interrupt_out_n)
        else $error("interrupt not released after flag read");
    AST_RESET_SHORT: assert property (module_ready && low_cnt_reg < 32'h1E0 |=> module_ready)
        else $error("short reset pulse recognised");
    AST_RESET_LONG: assert property (low_cnt_reg == 32'h208 |-> !module_ready)
        else $error("long reset pulse ignored");
endmodule
bind mct_module_control mct_module_control_properties #(.INIT_CYCLES(INIT_CYCLES)) i_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .module_reset_n(module_reset_n),
    .low_power_request(low_power_request), .module_select_n(module_select_n),
    .cond_in(cond_in), .interrupt_out_n(interrupt_out_n), .low_power_mode(low_power_mode),
    .serial_bus_enable(serial_bus_enable), .module_ready(module_ready)
);
`default_nettype wire

// ==== test/testbench.sv ====
// testbench: register bus master and sideband stimulus for mct_module_control
// assumes mct_host_sideband drives the module reset pin
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mct_pkg::*;
    logic         aclk, aresetn, awvalid, wvalid, arvalid, sel_n, lp_req, go;
    logic         awready, wready, bvalid, arready, rvalid, int_n, lp_mode, bus_en;
    logic         ready, rst_n, busy;
    logic [7:0]   awaddr, araddr;
    logic [31:0]  wdata, rdata, rd;
    logic [1:0]   bresp, rresp, rs;
    logic [15:0]  plen;
    logic [11:0]  pat;
    logic [3:0]   wstrb;
    mct_cond_type cond;
    int           num_errors, n_checks;
    // short init keeps the run brief; bounds derive from it
    mct_module_control #(.INIT_CYCLES(32'h0000_0014)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .module_reset_n(rst_n),
        .low_power_request(lp_req), .module_select_n(sel_n), .cond_in(cond),
        .interrupt_out_n(int_n), .low_power_mode(lp_mode), .serial_bus_enable(bus_en),
        .module_ready(ready));
    mct_host_sideband i_host (.aclk(aclk), .pulse_go(go), .pulse_len(plen),
        .module_reset_n(rst_n), .pulse_busy(busy));
    ////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int   n = 0;
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok) && n < 50);
        while (!bvalid && n < 50) begin
            @(posedge aclk);
            n++;
        end
        rs = bresp;
        if (n >= 50) num_errors++;
    endtask
    task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
        int n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!arready && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (!rvalid && n < 50);
        d = rdata;
        rs = rresp;
        if (n >= 50) num_errors++;
    endtask
    task automatic wait_ready();
        int n = 0;
        while (ready !== 1'b1 && n < 60) begin
            @(posedge aclk);
            n++;
        end
        check("ready", {31'h0, ready}, 32'h1);
    endtask
    task automatic pulse(input logic [15:0] len);
        plen <= len;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        tick(2);
        while (busy) @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'hE3EE6B7F));
        {aresetn, awvalid, wvalid, arvalid, lp_req, go} = 6'h00;
        {awaddr, araddr, wdata, plen, sel_n, cond} = '0;
        sel_n = 1'b1;
        wstrb = 4'hF;
        tick(8);
        aresetn <= 1'b1;
        rdreg(ADDR_STATUS, rd);
        check("status init", rd, 32'h1);
        rdreg(ADDR_MASK, rd);
        check("mask reset", rd, 32'h0);
        wait_ready();
        tick(3);
        check("ready int", {31'h0, int_n}, 32'h0);
        rdreg(ADDR_STATUS, rd);
        check("not ready bit", rd & 32'h1, 32'h0);
        rdreg(ADDR_FLAGS, rd);
        check("ready flag", rd, 32'h1);
        tick(3);
        check("int released", {31'h0, int_n}, 32'h1);
        rdreg(8'h40, rd);
        check("unmapped resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'h0000_0000);
        check("unmapped wr resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        wr(ADDR_FLAGS, 32'hFFFF_FFFF);
        check("flags wr resp", {30'h0, rs}, {30'h0, RESP_OKAY});
        rdreg(ADDR_FLAGS, rd);
        check("flags read only", rd, 32'h0);
        sel_n <= 1'b0;
        tick(3);
        check("bus on", {31'h0, bus_en}, 32'h1);
        for (int i = 0; i < 7; i++) begin
            pat = (i < 3) ? (12'h00F << (4 * i)) : 12'($urandom() % 32'd4095 + 32'd1);
            cond <= mct_cond_type'(pat);
            tick(3);
            check("cond int", {31'h0, int_n}, 32'h0);
            rdreg(ADDR_FLAGS, rd);
            check("flags", rd, {19'h0, pat, 1'b0});
            cond <= '0;
            tick(3);
            check("cleared int", {31'h0, int_n}, 32'h1);
        end
        wr(ADDR_MASK, 32'h0000_1FFF);
        rdreg(ADDR_MASK, rd);
        check("mask rw", rd, 32'h0000_1FFF);
        cond <= mct_cond_type'(12'hFFF);
        tick(3);
        check("masked int", {31'h0, int_n}, 32'h1);
        wr(ADDR_MASK, 32'h0);
        tick(3);
        check("unmasked int", {31'h0, int_n}, 32'h0);
        rdreg(ADDR_FLAGS, rd);
        check("masked flags", rd, 32'h0000_1FFE);
        // only byte 0 of the mask may change
        wstrb <= 4'h1;
        wr(ADDR_MASK, 32'h0000_1FFF);
        wstrb <= 4'hF;
        rdreg(ADDR_MASK, rd);
        check("mask strobe", rd, 32'h0000_00FF);
        cond <= '0;
        lp_req <= 1'b1;
        tick(3);
        check("lp pin", {31'h0, lp_mode}, 32'h1);
        lp_req <= 1'b0;
        wr(ADDR_CONTROL, 32'h1);
        tick(3);
        check("pdown on", {31'h0, lp_mode}, 32'h1);
        wr(ADDR_CONTROL, 32'h0);
        tick(3);
        check("pdown off", {30'h0, lp_mode, ready}, 32'h1);
        pulse(16'h0064);
        check("short pulse", {31'h0, ready}, 32'h1);
        pulse(16'h0258);
        check("long pulse", {31'h0, ready}, 32'h0);
        wait_ready();
        tick(3);
        check("reinit int", {31'h0, int_n}, 32'h0);
        sel_n <= 1'b1;
        tick(3);
        check("bus off", {31'h0, bus_en}, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
